// *** rtl/pwmart_pkg.sv ***
package pwmart_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] PWMART_CSR_ADDR   = 3'h0;
  localparam logic [2:0] PWMART_CAR_ADDR   = 3'h1;
  localparam logic [2:0] PWMART_ARR_ADDR   = 3'h2;
  localparam logic [2:0] PWMART_PWM_CTRL_REG_ADDR = 3'h3;
  localparam logic [2:0] PWMART_DCR0_ADDR  = 3'h4;
  localparam logic [2:0] PWMART_DCR1_ADDR  = 3'h5;

  // Control/status field positions
  localparam int PWMART_EXT_CLOCK_SELECT_BIT = 7;
  localparam int PWMART_CC_LSB   = 4;
  localparam int PWMART_TCE_BIT  = 3;
  localparam int PWMART_FORCE_RELOAD_BIT = 2;
  localparam int PWMART_OIE_BIT  = 1;
  localparam int PWMART_OVF_BIT  = 0;

  // PWM control field positions
  localparam int PWMART_OE_LSB = 4;
  localparam int PWMART_OP_LSB = 0;

  localparam logic [7:0] PWMART_RESET_BYTE = 8'h00;
  localparam logic [7:0] PWMART_COUNT_MAX  = 8'hFF;
  localparam logic [6:0] PWMART_PRESC_ZERO = 7'h00;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pwmart_bus_t;

endpackage

// *** rtl/pwmart_timer.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Eight-bit counter advances once per prescaler output tick.
// - Counter access register reads or writes live counter while running.
// - Overflow reloads counter from reload value; prescaler untouched.
// - Seven-bit prescaler, three-bit select picks divide by 2^n.
// - Prescaler input is CPU clock or external input, by select bit.
// - Run bit clear freezes prescaler and counter; set lets them count.
// - Reset clears counter, prescaler, and selects CPU clock.
// - Force reload written with the run bit set, or counter access write, initialise counter, clear prescaler.
// - Hidden compare per channel copied from duty register at overflow.
// - Two PWM outputs, each with own push-pull output enable.
// - Shared period is 256 minus reload value counter clocks.
// - Overflow drives each output with duty above reload to the inverse of its polarity bit.
// - Counter equal to compare value restores the other level.
// - Reload zero gives 1/256 resolution; polarity gives 0 and 100%.
// - PWM generation stops during halt mode.
// - Overflow sets sticky flag; interrupt requested when enabled.
// - External clock makes it an event counter of 256 minus reload events.
// - Timer issues wake-up request out of wait and halt modes.
// - Duty 00h holds output at its polarity level; duty FFh reaches that level for one count only.
// - Force reload bit is write-only and reads back zero.
// - Reading control/status register clears the overflow flag.
module pwmart_timer
  import pwmart_pkg::*;
#(
  parameter int CH = 2
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire pwmart_pkg::pwmart_bus_t bus,
  output logic [7:0]             rdata,
  input  wire logic              ext_clk_in,
  input  wire logic              halt_mode,
  output logic                   irq,
  output logic                   wakeup,
  output logic [CH-1:0]          pwm_out,
  output logic [CH-1:0]          pwm_oe
);
  import pwmart_pkg::*;

  // Address match, shared by write and read decoding
  function automatic logic addr_is(
    input pwmart_bus_t b,
    input logic [2:0]  a
  );
    return b.addr == a;
  endfunction

  // Control register state
  logic            ext_clock_select_q;
  logic            ext_clock_select_d;
  logic [2:0]      clock_divider_select_q;
  logic [2:0]      clock_divider_select_d;
  logic            counter_run_q;
  logic            counter_run_d;
  logic            overflow_irq_enable_q;
  logic            overflow_irq_enable_d;
  logic            overflow_flag_q;
  logic            overflow_flag_d;
  logic [7:0]      reload_value_q;
  logic [7:0]      reload_value_d;
  logic [CH-1:0]   pwm_output_enable_q;
  logic [CH-1:0]   pwm_output_enable_d;
  logic [CH-1:0]   pwm_polarity_q;
  logic [CH-1:0]   pwm_polarity_d;

  // Per-channel duty, hidden compare and level state
  logic [7:0]      duty_cycle_q [CH];
  logic [7:0]      duty_cycle_d [CH];
  logic [7:0]      compare_shadow_q [CH];
  logic [7:0]      compare_shadow_d [CH];
  logic [CH-1:0]   restored_q;
  logic [CH-1:0]   restored_d;

  // Counter and prescaler
  logic [7:0]      count_q;
  logic [7:0]      count_d;
  logic [6:0]      presc_q;
  logic [6:0]      presc_d;

  // Output registers
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic [CH-1:0]   pwm_out_q;
  logic [CH-1:0]   pwm_out_d;
  logic [CH-1:0]   pwm_oe_q;
  logic [CH-1:0]   pwm_oe_d;
  logic            irq_q;
  logic            irq_d;
  logic            wakeup_q;
  logic            wakeup_d;

  // External input and halt are asynchronous: two-stage synchronisers
  logic [1:0]      ext_sync_q;
  logic [1:0]      ext_sync_d;
  logic [1:0]      halt_sync_q;
  logic [1:0]      halt_sync_d;
  logic            ext_prev_q;
  logic            ext_prev_d;

  // Bus decode
  wire             wr_csr   = bus.wr && addr_is(bus, PWMART_CSR_ADDR);
  wire             wr_car   = bus.wr && addr_is(bus, PWMART_CAR_ADDR);
  wire             wr_arr   = bus.wr && addr_is(bus, PWMART_ARR_ADDR);
  wire             wr_pwm_ctrl_reg = bus.wr && addr_is(bus, PWMART_PWM_CTRL_REG_ADDR);
  wire             rd_csr   = bus.rd && addr_is(bus, PWMART_CSR_ADDR);
  // Reload needs the run bit in the same write, else it is ignored
  wire             force_reload =
                     wr_csr && bus.wdata[PWMART_FORCE_RELOAD_BIT]
                     && bus.wdata[PWMART_TCE_BIT];

  // Input tick: one per CPU cycle, or per rising external edge
  wire             ext_rise = ext_sync_q[1] && !ext_prev_q;
  wire             in_tick  = ext_clock_select_q ? ext_rise : 1'b1;

  // Tap n fires when the low n prescaler bits are all ones
  wire  [7:0]      presc_ext  = {1'b1, presc_q};
  wire  [3:0]      tap_shift  = 4'd8 - {1'b0, clock_divider_select_q};
  wire  [7:0]      tap_mask   = 8'hFF >> tap_shift;
  wire             tap_hit    = ((presc_ext | ~tap_mask) == 8'hFF);
  wire             run_tick   = counter_run_q && in_tick;
  wire             cnt_tick   = run_tick && tap_hit;
  wire  [7:0]      count_next = count_q + 8'h01;
  wire  [6:0]      presc_next = presc_q + 7'h01;
  wire             overflow   = cnt_tick && (count_q == PWMART_COUNT_MAX);
  wire             halted     = halt_sync_q[1];
  wire             irq_level  = overflow_flag_q && overflow_irq_enable_q;

  // Read mux; force reload always reads as zero
  logic [7:0]      rd_mux;
  assign rd_mux =
    addr_is(bus, PWMART_CSR_ADDR) ?
      {ext_clock_select_q, clock_divider_select_q, counter_run_q,
       1'b0, overflow_irq_enable_q, overflow_flag_q} :
    addr_is(bus, PWMART_CAR_ADDR) ? count_q :
    addr_is(bus, PWMART_ARR_ADDR) ? reload_value_q :
    addr_is(bus, PWMART_PWM_CTRL_REG_ADDR) ?
      {2'b00, pwm_output_enable_q, 2'b00, pwm_polarity_q} :
    addr_is(bus, PWMART_DCR0_ADDR) ? duty_cycle_q[0] :
    addr_is(bus, PWMART_DCR1_ADDR) ? duty_cycle_q[CH-1] :
    PWMART_RESET_BYTE;

  // Synchroniser next values; only the second stage feeds logic
  assign ext_sync_d  = {ext_sync_q[0], ext_clk_in};
  assign halt_sync_d = {halt_sync_q[0], halt_mode};
  assign ext_prev_d  = ext_sync_q[1];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_sync_q  <= 2'b00;
      halt_sync_q <= 2'b00;
      ext_prev_q  <= 1'b0;
    end else begin
      ext_sync_q  <= ext_sync_d;
      halt_sync_q <= halt_sync_d;
      ext_prev_q  <= ext_prev_d;
    end
  end

  // Control register next values
  always_comb begin
    ext_clock_select_d     = ext_clock_select_q;
    clock_divider_select_d = clock_divider_select_q;
    counter_run_d          = counter_run_q;
    overflow_irq_enable_d  = overflow_irq_enable_q;
    reload_value_d         = reload_value_q;
    pwm_output_enable_d    = pwm_output_enable_q;
    pwm_polarity_d         = pwm_polarity_q;
    if (wr_csr) begin
      ext_clock_select_d     = bus.wdata[PWMART_EXT_CLOCK_SELECT_BIT];
      clock_divider_select_d = bus.wdata[PWMART_CC_LSB +: 3];
      counter_run_d          = bus.wdata[PWMART_TCE_BIT];
      overflow_irq_enable_d  = bus.wdata[PWMART_OIE_BIT];
    end
    if (wr_arr) begin
      reload_value_d = bus.wdata;
    end
    if (wr_pwm_ctrl_reg) begin
      pwm_output_enable_d = bus.wdata[PWMART_OE_LSB +: CH];
      pwm_polarity_d      = bus.wdata[PWMART_OP_LSB +: CH];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_clock_select_q     <= 1'b0;
      clock_divider_select_q <= 3'h0;
      counter_run_q          <= 1'b0;
      overflow_irq_enable_q  <= 1'b0;
    end else begin
      ext_clock_select_q     <= ext_clock_select_d;
      clock_divider_select_q <= clock_divider_select_d;
      counter_run_q          <= counter_run_d;
      overflow_irq_enable_q  <= overflow_irq_enable_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reload_value_q <= PWMART_RESET_BYTE;
    end else begin
      reload_value_q <= reload_value_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwm_output_enable_q <= '0;
      pwm_polarity_q      <= '0;
    end else begin
      pwm_output_enable_q <= pwm_output_enable_d;
      pwm_polarity_q      <= pwm_polarity_d;
    end
  end

  // Overflow flag: a hardware set beats the read-clear in one cycle
  always_comb begin
    overflow_flag_d = overflow_flag_q;
    if (overflow) begin
      overflow_flag_d = 1'b1;
    end else if (rd_csr) begin
      overflow_flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      overflow_flag_q <= 1'b0;
    end else begin
      overflow_flag_q <= overflow_flag_d;
    end
  end

  // Counter and prescaler next values; a bus load clears the prescaler
  always_comb begin
    count_d = count_q;
    presc_d = presc_q;
    if (wr_car) begin
      count_d = bus.wdata;
      presc_d = PWMART_PRESC_ZERO;
    end else if (force_reload) begin
      count_d = reload_value_q;
      presc_d = PWMART_PRESC_ZERO;
    end else if (run_tick) begin
      presc_d = presc_next;
      if (overflow) begin
        count_d = reload_value_q;
      end else if (cnt_tick) begin
        count_d = count_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_q <= PWMART_RESET_BYTE;
      presc_q <= PWMART_PRESC_ZERO;
    end else begin
      count_q <= count_d;
      presc_q <= presc_d;
    end
  end

  // Per-channel compare and output level
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : gen_ch
      wire duty_wr   = bus.wr && addr_is(bus, PWMART_DCR0_ADDR + 3'(g));
      wire shadow_ld = !halted && overflow;
      wire cmp_hit   = !halted && cnt_tick
                       && (count_next == compare_shadow_q[g]);
      // Duty at or below reload never goes active in the period
      wire never_act = (duty_cycle_q[g] <= reload_value_q);

      assign duty_cycle_d[g]     = duty_wr ? bus.wdata : duty_cycle_q[g];
      assign compare_shadow_d[g] = shadow_ld ? duty_cycle_q[g]
                                             : compare_shadow_q[g];

      // Frozen in halt, so the pin keeps its last level
      assign restored_d[g] = shadow_ld ? never_act :
                             cmp_hit   ? 1'b1 :
                             restored_q[g];

      // Polarity change shows at once, without waiting for overflow
      assign pwm_out_d[g] = restored_q[g] ? pwm_polarity_q[g]
                                          : ~pwm_polarity_q[g];
      assign pwm_oe_d[g]  = pwm_output_enable_q[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < CH; i++) begin
        duty_cycle_q[i] <= PWMART_RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        duty_cycle_q[i] <= duty_cycle_d[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < CH; i++) begin
        compare_shadow_q[i] <= PWMART_RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        compare_shadow_q[i] <= compare_shadow_d[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      restored_q <= '0;
    end else begin
      restored_q <= restored_d;
    end
  end

  // Read data, interrupt and wake-up next values
  assign rdata_d  = bus.rd ? rd_mux : PWMART_RESET_BYTE;
  assign irq_d    = irq_level;
  assign wakeup_d = irq_level;

  // Every output leaves from a flip-flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= PWMART_RESET_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wakeup_q <= 1'b0;
    end else begin
      wakeup_q <= wakeup_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwm_out_q <= '0;
    end else begin
      pwm_out_q <= pwm_out_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwm_oe_q <= '0;
    end else begin
      pwm_oe_q <= pwm_oe_d;
    end
  end

  assign rdata   = rdata_q;
  assign irq     = irq_q;
  assign wakeup  = wakeup_q;
  assign pwm_out = pwm_out_q;
  assign pwm_oe  = pwm_oe_q;

endmodule

// *** bench/pwmart_timer_assertions.sv ***
`timescale 1ns/1ps
module pwmart_timer_assertions
  import pwmart_pkg::*;
#(
  parameter int CH = 2
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire pwmart_pkg::pwmart_bus_t bus,
  input wire logic [7:0]              rdata,
  input wire logic                    ext_clk_in,
  input wire logic                    halt_mode,
  input wire logic                    irq,
  input wire logic                    wakeup,
  input wire logic [CH-1:0]           pwm_out,
  input wire logic [CH-1:0]           pwm_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire csr_rd = bus.rd && bus.addr == 3'h0;
  wire csr_wr = bus.wr && bus.addr == 3'h0;
  wire pcr_wr = bus.wr && bus.addr == 3'h3;
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_reload_rz: assert property (csr_rd |=> !rdata[2])
    else $error("force reload reads back set");
  a_wake_irq: assert property (wakeup == irq)
    else $error("wakeup differs from irq");
  a_irq_mask: assert property (csr_wr && !bus.wdata[1] |=> ##1 !irq)
    else $error("irq while masked");
  a_oe_follow: assert property (pcr_wr ##1 !pcr_wr |=>
    pwm_oe == $past(bus.wdata[5:4], 2)) else $error("enable not applied");
  a_reset_quiet: assert property ($rose(resetn) |->
    !irq && pwm_oe == '0 && pwm_out == '0) else $error("not quiet");
  a_halt_hold: assert property ((halt_mode && !bus.wr) [*4]
    |=> $stable(pwm_out)) else $error("pwm moved in halt");
  a_rsvd_zero: assert property (bus.rd && bus.addr == 3'h3
    |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0) else $error("reserved set");
endmodule
bind pwmart_timer pwmart_timer_assertions #(.CH(CH)) u_pwmart_chk (
  .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
  .ext_clk_in(ext_clk_in), .halt_mode(halt_mode), .irq(irq),
  .wakeup(wakeup), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import pwmart_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ext_clk_in = 1'b0;
  logic        halt_mode = 1'b0;
  pwmart_bus_t bus = '0;
  logic [7:0]  rdata, got, d0, d1;
  logic [1:0]  pwm_out, pwm_oe, snap;
  logic        irq, wakeup;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          seed = 5363;
  int          k, h0, h1;
  always #10 clk = ~clk;
  pwmart_timer u_pwmart_timer (.clk(clk), .resetn(resetn), .bus(bus),
    .rdata(rdata), .ext_clk_in(ext_clk_in), .halt_mode(halt_mode),
    .irq(irq), .wakeup(wakeup), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // High cycles in one 256-count period for a duty and polarity
  function automatic logic [7:0] exp_high(input logic [7:0] d,
                                          input logic       p);
    return p ? 8'h00 - d : d;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 got = rdata;
  endtask
  task automatic pulse;
    repeat (4) @(posedge clk);
    ext_clk_in <= 1'b1;
    repeat (4) @(posedge clk);
    ext_clk_in <= 1'b0;
  endtask
  // Counts high cycles over one full 256-count period
  task automatic measure;
    h0 = 0;
    h1 = 0;
    repeat (256) begin
      @(posedge clk);
      #1 h0 += pwm_out[0];
      h1 += pwm_out[1];
    end
  endtask
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i));
      chk(got, 8'h00);
    end
    d0 = 8'($random(seed));
    wr(3'h1, d0);
    repeat (20) @(posedge clk);
    rd(3'h1);
    chk(got, d0);
    wr(3'h2, 8'h80);
    wr(3'h0, 8'h7C);
    rd(3'h1);
    chk(got, 8'h80);
    rd(3'h0);
    chk(got, 8'h78);
    for (int n = 2; n < 8; n++) begin
      k = ($random(seed) & 3) + 1;
      wr(3'h0, 8'(n * 16 + 8));
      wr(3'h1, 8'h00);
      // Mid-period read hides a one-cycle start skew
      repeat (k * (1 << n) + (1 << (n - 1)) - 2) @(posedge clk);
      rd(3'h1);
      chk(got, 8'(k));
    end
    wr(3'h2, 8'hF0);
    wr(3'h0, 8'h2A);
    wr(3'h1, 8'hFE);
    repeat (12) @(posedge clk);
    rd(3'h1);
    chk(got, 8'hF1);
    chk({6'h00, irq, wakeup}, 8'h03);
    rd(3'h0);
    chk(got, 8'h2B);
    rd(3'h0);
    chk(got, 8'h2A);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    d0 = 8'h10 + 8'($random(seed) & 8'hBF);
    d1 = 8'h10 + 8'($random(seed) & 8'hBF);
    wr(3'h2, 8'h00);
    wr(3'h4, d0);
    wr(3'h5, d1);
    wr(3'h3, 8'h30);
    wr(3'h0, 8'h08);
    repeat (600) @(posedge clk);
    measure;
    chk(8'(h0), exp_high(d0, 1'b0));
    chk(8'(h1), exp_high(d1, 1'b0));
    chk({6'h00, pwm_oe}, 8'h03);
    wr(3'h3, 8'h13);
    repeat (8) @(posedge clk);
    measure;
    chk(8'(h0), exp_high(d0, 1'b1));
    chk({6'h00, pwm_oe}, 8'h01);
    @(posedge clk) halt_mode <= 1'b1;
    repeat (5) @(posedge clk);
    snap = pwm_out;
    measure;
    chk({7'h00, h0 == 256 * snap[0]}, 8'h01);
    @(posedge clk) halt_mode <= 1'b0;
    wr(3'h0, 8'h88);
    wr(3'h2, 8'hFD);
    wr(3'h1, 8'hFD);
    rd(3'h0);
    repeat (2) pulse;
    rd(3'h1);
    chk(got, 8'hFF);
    pulse;
    rd(3'h0);
    chk(got, 8'h89);
    end_sim;
  end
endmodule
